// >>> core/scpmc_consts.vh
`ifndef SCPMC_CONSTS_VH
`define SCPMC_CONSTS_VH

// APB register byte offsets
`define SCPMC_ADDR_W       8
`define SCPMC_OFF_MODE     8'h00
`define SCPMC_OFF_NORMAL   8'h04
`define SCPMC_OFF_STOP     8'h08
`define SCPMC_OFF_PDIV     8'h0C
`define SCPMC_OFF_BDIV     8'h10
`define SCPMC_OFF_HGATE    8'h14
`define SCPMC_OFF_PGATE    8'h18
`define SCPMC_OFF_SGATE    8'h1C
`define SCPMC_OFF_OSCCNT   8'h20
`define SCPMC_OFF_PWRCNT   8'h24
`define SCPMC_OFF_LOCKCNT  8'h28
`define SCPMC_OFF_PLLCTL   8'h2C
`define SCPMC_OFF_STATUS   8'h30

// Power mode field and encodings
`define SCPMC_MODE_HI      6
`define SCPMC_MODE_LO      5
`define SCPMC_MODE_NONE    2'h0
`define SCPMC_MODE_IDLE    2'h1
`define SCPMC_MODE_STOP    2'h2
`define SCPMC_MODE_SLEEP   2'h3

// Stop-mode configuration bit positions
`define SCPMC_STOP_PLOGIC  29
`define SCPMC_STOP_PMEM    17
`define SCPMC_STOP_TLOGIC  30
`define SCPMC_STOP_TMEM    19

// Field widths and positions
`define SCPMC_NDOM         6
`define SCPMC_DIV_W        4
`define SCPMC_CNT_W        16
`define SCPMC_NPLL         3
`define SCPMC_PLL_SRC_BIT  3
`define SCPMC_BDIV_H_LO    0
`define SCPMC_BDIV_P_LO    4
`define SCPMC_BDIV_S_LO    8
`define SCPMC_STAT_EXT_BIT 8
`define SCPMC_STAT_REG_BIT 9
`define SCPMC_STAT_PRST_BIT 10

// Reset values
`define SCPMC_RST_MODE     2'h0
`define SCPMC_RST_NORMAL   6'h3F
`define SCPMC_RST_STOP     32'h600A0000
`define SCPMC_RST_GATE     32'hFFFFFFFF
`define SCPMC_RST_DIV      4'h0
`define SCPMC_RST_BDIV     12'h000
`define SCPMC_RST_PLLCTL   4'h0
`define SCPMC_RST_OSCCNT   16'h0100
`define SCPMC_RST_PWRCNT   16'h0100

// Timing
`define SCPMC_CLK_MHZ      20
`define SCPMC_PLL_LOCK_US  300
`define SCPMC_STRAP_WAIT   2'h3

`endif

// >>> core/scpmc_clk_div.v
`timescale 1ns/1ns
`include "scpmc_consts.vh"

module scpmc_clk_div #(
  parameter W = `SCPMC_DIV_W
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         rst_n,
  // Control
  input  wire         run,
  input  wire [W-1:0] ratioM1,
  // Divided clock level
  output wire         clkOut
);

  reg [W-1:0] cnt_q;
  reg         clk_q;

  // Each half period lasts ratioM1+1 cycles; a smaller new ratio is caught by >=
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {W{1'b0}};
      clk_q <= 1'b0;
    end else if (!run) begin
      cnt_q <= {W{1'b0}}; // Frozen low so a restart gives whole pulses
      clk_q <= 1'b0;
    end else if (cnt_q >= ratioM1) begin
      cnt_q <= {W{1'b0}};
      clk_q <= ~clk_q;
    end else begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign clkOut = clk_q;

endmodule

// >>> core/scpmc_clk_gate.v
`timescale 1ns/1ns

module scpmc_clk_gate #(
  parameter W = 32
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         rst_n,
  // Source clock and enables
  input  wire         clkIn,
  input  wire [W-1:0] enIn,
  // Gated clocks
  output wire [W-1:0] clkOut
);

  reg [W-1:0] en_q;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // Enable only moves while the source is low, so no pulse is clipped
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          en_q[i] <= 1'b1;
        end else if (!clkIn) begin
          en_q[i] <= enIn[i];
        end
      end
      assign clkOut[i] = clkIn & en_q[i];
    end
  endgenerate

endmodule

// >>> core/scpmc_top.v
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "scpmc_consts.vh"

module scpmc_top #(
  parameter [`SCPMC_CNT_W-1:0] PLL_LOCK_CYCLES = `SCPMC_PLL_LOCK_US * `SCPMC_CLK_MHZ,
  parameter                    GATE_W          = 32
) (
  // Clock and reset
  input  wire                    sys_clk,
  input  wire                    rst_n,
  // APB slave
  input  wire [`SCPMC_ADDR_W-1:0] paddr,
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [31:0]             pwdata,
  output reg  [31:0]             prdata,
  output wire                    pready,
  output reg                     pslverr,
  // Pins
  input  wire                    opModeStrap,
  input  wire                    wakeupEvent,
  output reg                     regulatorEnableOut,
  // Processor
  input  wire                    standbyWaitInterrupt,
  output wire                    processorClock,
  output reg                     procResetN,
  output reg                     procLogicPowerOn,
  output reg                     procMemPowerOn,
  // Top module and sub-domains
  output reg                     topLogicPowerOn,
  output reg                     topMemPowerOn,
  output reg  [`SCPMC_NDOM-1:0]  domainPowerOn,
  // Bus and memory controller handshakes
  output reg                     ahbDownReq,
  input  wire                    ahbDownAck,
  output reg                     axiDownReq,
  input  wire                    axiDownAck,
  output reg                     selfRefreshReq,
  input  wire                    selfRefreshAck,
  output reg                     busResetN,
  // Clock sources
  output reg                     refSelExternal,
  output reg                     oscEnable,
  output reg  [`SCPMC_NPLL-1:0]  pllEnable,
  output reg  [`SCPMC_NPLL-1:0]  clkFromPll,
  // Gated clocks
  output wire [GATE_W-1:0]       hclkGated,
  output wire [GATE_W-1:0]       pclkGated,
  output wire [GATE_W-1:0]       sclkGated
);

  // Power sequencer states
  localparam [3:0] ST_NORMAL   = 4'h0;
  localparam [3:0] ST_IDLE     = 4'h1;
  localparam [3:0] ST_ENT_AHB  = 4'h2;
  localparam [3:0] ST_ENT_AXI  = 4'h3;
  localparam [3:0] ST_ENT_SREF = 4'h4;
  localparam [3:0] ST_ENT_OFF  = 4'h5;
  localparam [3:0] ST_LOW      = 4'h6;
  localparam [3:0] ST_WAKE_PWR = 4'h7;
  localparam [3:0] ST_WAKE_OSC = 4'h8;
  localparam [3:0] ST_WAKE_PLL = 4'h9;
  localparam [3:0] ST_WAKE_REL = 4'hA;
  localparam [3:0] ST_WAKE_RST = 4'hB;

  // Software registers
  reg [1:0]                modeSel_q;
  reg [`SCPMC_NDOM-1:0]    normalCfg_q;
  reg [31:0]               stopCfg_q;
  reg [`SCPMC_DIV_W-1:0]   procDiv_q;
  reg [11:0]               busDiv_q;
  reg [GATE_W-1:0]         hGate_q;
  reg [GATE_W-1:0]         pGate_q;
  reg [GATE_W-1:0]         sGate_q;
  reg [`SCPMC_CNT_W-1:0]   oscCnt_q;
  reg [`SCPMC_CNT_W-1:0]   pwrCnt_q;
  reg [`SCPMC_CNT_W-1:0]   lockCnt_q;
  reg [3:0]                pllCtl_q;

  // Sequencer state
  reg [3:0]                state_q;
  reg [`SCPMC_CNT_W-1:0]   wait_q;
  reg                      sleep_q;
  reg                      deep_q;
  reg                      oscForce_q;
  reg                      pllHold_q;

  // Synchronisers and strap capture
  reg                      strapS1_q;
  reg                      strapS2_q;
  reg                      wakeS1_q;
  reg                      wakeS2_q;
  reg [1:0]                strapCnt_q;

  wire                     wrEn;
  wire                     rdSetup;
  wire                     inLow;
  wire                     waitDone;
  wire                     clkRun;
  wire                     procRun;
  wire                     procDivClk;
  wire                     hDivClk;
  wire                     pDivClk;
  wire                     sDivClk;
  reg  [31:0]              rdMux;
  reg                      rdHit;

  // Zero-wait slave: every access phase completes at once
  assign pready  = 1'b1;
  assign wrEn    = psel & penable & pwrite;
  assign rdSetup = psel & ~penable;

  // Domain power, and core and top power unless retained in stop, are held back from entry's end to clock release
  assign inLow    = (state_q == ST_ENT_OFF) | (state_q == ST_LOW) |
                    (state_q == ST_WAKE_PWR) | (state_q == ST_WAKE_OSC) |
                    (state_q == ST_WAKE_PLL);
  assign waitDone = (wait_q == {`SCPMC_CNT_W{1'b0}});

  // Whole timebase freezes while PLLs are held off
  assign clkRun  = ~pllHold_q;
  assign procRun = clkRun & (state_q != ST_IDLE) & procResetN;

  // Two-stage synchronisers; only stage two is read by logic
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strapS1_q <= 1'b0;
      strapS2_q <= 1'b0;
      wakeS1_q  <= 1'b0;
      wakeS2_q  <= 1'b0;
    end else begin
      strapS1_q <= opModeStrap;
      strapS2_q <= strapS1_q;
      wakeS1_q  <= wakeupEvent;
      wakeS2_q  <= wakeS1_q;
    end
  end

  // Strap is caught after release, once the synchroniser has filled, then frozen
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strapCnt_q     <= 2'h0;
      refSelExternal <= 1'b0;
    end else if (strapCnt_q != `SCPMC_STRAP_WAIT) begin
      strapCnt_q     <= strapCnt_q + 2'h1;
      refSelExternal <= strapS2_q;
    end
  end

  // Register writes
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeSel_q   <= `SCPMC_RST_MODE;
      normalCfg_q <= `SCPMC_RST_NORMAL;
      stopCfg_q   <= `SCPMC_RST_STOP;
      procDiv_q   <= `SCPMC_RST_DIV;
      busDiv_q    <= `SCPMC_RST_BDIV;
      hGate_q     <= `SCPMC_RST_GATE;
      pGate_q     <= `SCPMC_RST_GATE;
      sGate_q     <= `SCPMC_RST_GATE;
      oscCnt_q    <= `SCPMC_RST_OSCCNT;
      pwrCnt_q    <= `SCPMC_RST_PWRCNT;
      lockCnt_q   <= PLL_LOCK_CYCLES;
      pllCtl_q    <= `SCPMC_RST_PLLCTL;
    end else if (wrEn) begin
      case (paddr)
        `SCPMC_OFF_MODE:    modeSel_q   <= pwdata[`SCPMC_MODE_HI:`SCPMC_MODE_LO];
        `SCPMC_OFF_NORMAL:  normalCfg_q <= pwdata[`SCPMC_NDOM-1:0];
        `SCPMC_OFF_STOP:    stopCfg_q   <= pwdata;
        `SCPMC_OFF_PDIV:    procDiv_q   <= pwdata[`SCPMC_DIV_W-1:0];
        `SCPMC_OFF_BDIV:    busDiv_q    <= pwdata[11:0];
        `SCPMC_OFF_HGATE:   hGate_q     <= pwdata[GATE_W-1:0];
        `SCPMC_OFF_PGATE:   pGate_q     <= pwdata[GATE_W-1:0];
        `SCPMC_OFF_SGATE:   sGate_q     <= pwdata[GATE_W-1:0];
        `SCPMC_OFF_OSCCNT:  oscCnt_q    <= pwdata[`SCPMC_CNT_W-1:0];
        `SCPMC_OFF_PWRCNT:  pwrCnt_q    <= pwdata[`SCPMC_CNT_W-1:0];
        `SCPMC_OFF_LOCKCNT: lockCnt_q   <= pwdata[`SCPMC_CNT_W-1:0];
        `SCPMC_OFF_PLLCTL:  pllCtl_q    <= pwdata[3:0];
        default: begin
        end
      endcase
    end
  end

  // Read decode; status shows the sequencer state and live pins
  always @* begin
    rdMux = 32'h00000000;
    rdHit = 1'b1;
    case (paddr)
      `SCPMC_OFF_MODE:    rdMux[`SCPMC_MODE_HI:`SCPMC_MODE_LO] = modeSel_q;
      `SCPMC_OFF_NORMAL:  rdMux[`SCPMC_NDOM-1:0] = normalCfg_q;
      `SCPMC_OFF_STOP:    rdMux = stopCfg_q;
      `SCPMC_OFF_PDIV:    rdMux[`SCPMC_DIV_W-1:0] = procDiv_q;
      `SCPMC_OFF_BDIV:    rdMux[11:0] = busDiv_q;
      `SCPMC_OFF_HGATE:   rdMux[GATE_W-1:0] = hGate_q;
      `SCPMC_OFF_PGATE:   rdMux[GATE_W-1:0] = pGate_q;
      `SCPMC_OFF_SGATE:   rdMux[GATE_W-1:0] = sGate_q;
      `SCPMC_OFF_OSCCNT:  rdMux[`SCPMC_CNT_W-1:0] = oscCnt_q;
      `SCPMC_OFF_PWRCNT:  rdMux[`SCPMC_CNT_W-1:0] = pwrCnt_q;
      `SCPMC_OFF_LOCKCNT: rdMux[`SCPMC_CNT_W-1:0] = lockCnt_q;
      `SCPMC_OFF_PLLCTL:  rdMux[3:0] = pllCtl_q;
      `SCPMC_OFF_STATUS: begin
        rdMux[3:0]                  = state_q;
        rdMux[`SCPMC_STAT_EXT_BIT]  = refSelExternal;
        rdMux[`SCPMC_STAT_REG_BIT]  = regulatorEnableOut;
        rdMux[`SCPMC_STAT_PRST_BIT] = procResetN;
      end
      default: rdHit = 1'b0;
    endcase
  end

  // Read data and error are latched in the setup cycle, valid in the access cycle
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (rdSetup) begin
      prdata  <= pwrite ? 32'h00000000 : rdMux;
      pslverr <= ~rdHit;
    end
  end

  // Power mode sequencer
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q            <= ST_NORMAL;
      wait_q             <= {`SCPMC_CNT_W{1'b0}};
      sleep_q            <= 1'b0;
      deep_q             <= 1'b0;
      oscForce_q         <= 1'b0;
      pllHold_q          <= 1'b0;
      oscEnable          <= 1'b1;
      regulatorEnableOut <= 1'b1;
      ahbDownReq         <= 1'b0;
      axiDownReq         <= 1'b0;
      selfRefreshReq     <= 1'b0;
      busResetN          <= 1'b1;
      procResetN         <= 1'b1;
    end else begin
      if (!waitDone) begin
        wait_q <= wait_q - {{(`SCPMC_CNT_W-1){1'b0}}, 1'b1};
      end
      case (state_q)
        ST_NORMAL: begin
          if (standbyWaitInterrupt) begin
            case (modeSel_q)
              `SCPMC_MODE_IDLE: state_q <= ST_IDLE;
              `SCPMC_MODE_STOP, `SCPMC_MODE_SLEEP: begin
                sleep_q    <= (modeSel_q == `SCPMC_MODE_SLEEP);
                deep_q     <= ~stopCfg_q[`SCPMC_STOP_PLOGIC] &
                              ~stopCfg_q[`SCPMC_STOP_PMEM];
                ahbDownReq <= 1'b1;
                state_q    <= ST_ENT_AHB;
              end
              default: state_q <= ST_NORMAL;
            endcase
          end
        end
        ST_IDLE: begin
          if (wakeS2_q) begin
            state_q <= ST_NORMAL;
          end
        end
        ST_ENT_AHB: begin
          if (ahbDownAck) begin
            axiDownReq <= 1'b1;
            state_q    <= ST_ENT_AXI;
          end
        end
        ST_ENT_AXI: begin
          if (axiDownAck) begin
            selfRefreshReq <= 1'b1;
            state_q        <= ST_ENT_SREF;
          end
        end
        ST_ENT_SREF: begin
          if (selfRefreshAck) begin
            oscForce_q <= 1'b1;
            state_q    <= ST_ENT_OFF;
          end
        end
        ST_ENT_OFF: begin
          // Source is already on the oscillator, so PLLs stop without a glitch
          pllHold_q <= 1'b1;
          oscEnable <= 1'b0;
          if (sleep_q) begin
            regulatorEnableOut <= 1'b0;
            busResetN          <= 1'b0;
            procResetN         <= 1'b0;
          end else if (deep_q) begin
            procResetN <= 1'b0;
          end
          state_q <= ST_LOW;
        end
        ST_LOW: begin
          if (wakeS2_q) begin
            if (sleep_q) begin
              regulatorEnableOut <= 1'b1;
              wait_q             <= pwrCnt_q;
              state_q            <= ST_WAKE_PWR;
            end else begin
              oscEnable <= 1'b1;
              wait_q    <= oscCnt_q;
              state_q   <= ST_WAKE_OSC;
            end
          end
        end
        ST_WAKE_PWR: begin
          if (waitDone) begin
            oscEnable <= 1'b1;
            wait_q    <= oscCnt_q;
            state_q   <= ST_WAKE_OSC;
          end
        end
        ST_WAKE_OSC: begin
          if (waitDone) begin
            pllHold_q <= 1'b0;
            wait_q    <= lockCnt_q;
            state_q   <= ST_WAKE_PLL;
          end
        end
        ST_WAKE_PLL: begin
          if (waitDone) begin
            oscForce_q     <= 1'b0;
            selfRefreshReq <= 1'b0;
            state_q        <= ST_WAKE_REL;
          end
        end
        ST_WAKE_REL: begin
          if (!selfRefreshAck) begin
            ahbDownReq <= 1'b0;
            axiDownReq <= 1'b0;
            busResetN  <= 1'b1;
            state_q    <= ST_WAKE_RST;
          end
        end
        ST_WAKE_RST: begin
          procResetN <= 1'b1;
          sleep_q    <= 1'b0;
          deep_q     <= 1'b0;
          state_q    <= ST_NORMAL;
        end
        default: state_q <= ST_NORMAL;
      endcase
    end
  end

  // Power switches; retention parts stay on in stop so no restore is needed
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      domainPowerOn    <= `SCPMC_RST_NORMAL;
      procLogicPowerOn <= 1'b1;
      procMemPowerOn   <= 1'b1;
      topLogicPowerOn  <= 1'b1;
      topMemPowerOn    <= 1'b1;
    end else if (inLow) begin
      domainPowerOn    <= {`SCPMC_NDOM{1'b0}};
      procLogicPowerOn <= ~sleep_q & stopCfg_q[`SCPMC_STOP_PLOGIC];
      procMemPowerOn   <= ~sleep_q & stopCfg_q[`SCPMC_STOP_PMEM];
      topLogicPowerOn  <= ~sleep_q & stopCfg_q[`SCPMC_STOP_TLOGIC];
      topMemPowerOn    <= ~sleep_q & stopCfg_q[`SCPMC_STOP_TMEM];
    end else begin
      domainPowerOn    <= normalCfg_q;
      procLogicPowerOn <= 1'b1;
      procMemPowerOn   <= 1'b1;
      topLogicPowerOn  <= 1'b1;
      topMemPowerOn    <= 1'b1;
    end
  end

  // PLL enables and source selects; the oscillator wins during transitions
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pllEnable  <= {`SCPMC_NPLL{1'b0}};
      clkFromPll <= {`SCPMC_NPLL{1'b0}};
    end else begin
      pllEnable  <= pllCtl_q[`SCPMC_NPLL-1:0] & {`SCPMC_NPLL{~pllHold_q}};
      clkFromPll <= pllCtl_q[`SCPMC_NPLL-1:0] &
                    {`SCPMC_NPLL{pllCtl_q[`SCPMC_PLL_SRC_BIT] & ~oscForce_q}};
    end
  end

  // Processor divider on the processor PLL path
  scpmc_clk_div #(.W(`SCPMC_DIV_W)) u_proc_div (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .run     (clkRun),
    .ratioM1 (procDiv_q),
    .clkOut  (procDivClk)
  );

  // Bus and peripheral dividers share one timebase, so they stay in step
  scpmc_clk_div #(.W(`SCPMC_DIV_W)) u_hclk_div (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .run     (clkRun),
    .ratioM1 (busDiv_q[`SCPMC_BDIV_H_LO +: `SCPMC_DIV_W]),
    .clkOut  (hDivClk)
  );

  scpmc_clk_div #(.W(`SCPMC_DIV_W)) u_pclk_div (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .run     (clkRun),
    .ratioM1 (busDiv_q[`SCPMC_BDIV_P_LO +: `SCPMC_DIV_W]),
    .clkOut  (pDivClk)
  );

  // Special clocks on the extra PLL path
  scpmc_clk_div #(.W(`SCPMC_DIV_W)) u_sclk_div (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .run     (clkRun),
    .ratioM1 (busDiv_q[`SCPMC_BDIV_S_LO +: `SCPMC_DIV_W]),
    .clkOut  (sDivClk)
  );

  // Processor clock is gated for idle and core reset
  scpmc_clk_gate #(.W(1)) u_proc_gate (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clkIn   (procDivClk),
    .enIn    (procRun),
    .clkOut  (processorClock)
  );

  // Per-bit gates for the three clock groups
  scpmc_clk_gate #(.W(GATE_W)) u_hclk_gate (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clkIn   (hDivClk),
    .enIn    (hGate_q),
    .clkOut  (hclkGated)
  );

  scpmc_clk_gate #(.W(GATE_W)) u_pclk_gate (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clkIn   (pDivClk),
    .enIn    (pGate_q),
    .clkOut  (pclkGated)
  );

  scpmc_clk_gate #(.W(GATE_W)) u_sclk_gate (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clkIn   (sDivClk),
    .enIn    (sGate_q),
    .clkOut  (sclkGated)
  );

endmodule

// >>> tb/scpmc_partner.sv
`timescale 1ns/1ns
// Bus and memory controller stand-in; a slow setting stretches every handshake
module scpmc_partner (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // Answer delay in cycles
  input  wire [3:0]  ackDelay,
  // Handshakes
  input  wire        ahbDownReq,
  input  wire        axiDownReq,
  input  wire        selfRefreshReq,
  output logic       ahbDownAck,
  output logic       axiDownAck,
  output logic       selfRefreshAck
);
  logic [2:0] req;
  logic [3:0] wt;
  assign req = {selfRefreshReq, axiDownReq, ahbDownReq};
  // Acks follow their request levels after the delay, raise and release alike
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {selfRefreshAck, axiDownAck, ahbDownAck} <= 3'h0;
      wt <= 4'h0;
    end else if (req == {selfRefreshAck, axiDownAck, ahbDownAck}) begin
      wt <= 4'h0;
    end else if (wt >= ackDelay) begin
      {selfRefreshAck, axiDownAck, ahbDownAck} <= req;
      wt <= 4'h0;
    end else begin
      wt <= wt + 4'h1;
    end
  end
endmodule

// >>> tb/scpmc_assertions.sv
`timescale 1ns/1ns
// Entry and wake ordering seen from the top ports
module scpmc_assertions #(
  parameter GATE_W = 32
) (
  // Clock and reset
  input wire              sys_clk,
  input wire              rst_n,
  // Observed ports
  input wire              standbyWaitInterrupt,
  input wire              ahbDownReq,
  input wire              ahbDownAck,
  input wire              axiDownReq,
  input wire              axiDownAck,
  input wire              selfRefreshReq,
  input wire              selfRefreshAck,
  input wire              oscEnable,
  input wire              regulatorEnableOut,
  input wire              busResetN,
  input wire              procResetN,
  input wire              processorClock,
  input wire [2:0]        pllEnable,
  input wire [5:0]        domainPowerOn,
  input wire [GATE_W-1:0] hclkGated
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Entry steps forward one acknowledge at a time
  entry_start_a: assert property ($rose(ahbDownReq) |-> $past(standbyWaitInterrupt))
    else $error("bus down without wfi");
  axi_order_a: assert property ($rose(axiDownReq) |-> ahbDownReq && $past(ahbDownAck))
    else $error("axi request before ahb ack");
  sref_order_a: assert property ($rose(selfRefreshReq) |-> $past(axiDownAck))
    else $error("refresh request before axi ack");
  // Sources drop only once memory holds itself
  pll_off_a: assert property ($fell(oscEnable) |-> selfRefreshAck ##1 pllEnable == 3'h0)
    else $error("sources off too early");
  domain_off_a: assert property ($fell(oscEnable) |=> domainPowerOn == 6'h00)
    else $error("domain left powered");
  clk_freeze_a: assert property (
    !oscEnable && !$past(oscEnable, 2) |-> $stable(hclkGated) && !processorClock)
    else $error("clock ran while frozen");
  reg_off_a: assert property (
    $fell(regulatorEnableOut) |-> !oscEnable && !busResetN && !procResetN)
    else $error("regulator off while live");
  reg_on_a: assert property ($rose(regulatorEnableOut) |-> !oscEnable [*2])
    else $error("oscillator before power settle");
  // Wake releases refresh first, then both bus requests together, then core reset
  wake_sref_a: assert property (
    $fell(selfRefreshReq) |-> oscEnable && ahbDownReq && axiDownReq)
    else $error("refresh released out of order");
  wake_rel_a: assert property (
    $fell(ahbDownReq) |-> !selfRefreshReq && busResetN ##1 procResetN)
    else $error("core reset not released");
endmodule

bind scpmc_top scpmc_assertions #(.GATE_W(GATE_W)) i_chk (
  .sys_clk, .rst_n, .standbyWaitInterrupt, .ahbDownReq, .ahbDownAck, .axiDownReq,
  .axiDownAck, .selfRefreshReq, .selfRefreshAck, .oscEnable, .regulatorEnableOut,
  .busResetN, .procResetN, .processorClock, .pllEnable, .domainPowerOn, .hclkGated
);

// >>> tb/scpmc_top_bench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin badCount++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
`define WAITV(c) begin wn = 0; while (!(c) && wn < 3000) begin \
  @(negedge sys_clk); wn++; end end
module scpmc_top_bench;
  // Driven inputs
  logic        sys_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        opModeStrap = 1'h1, wakeupEvent = 1'h0, standbyWaitInterrupt = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, hclkGated, pclkGated, sclkGated;
  logic [3:0]  ackDelay = 4'h0;
  // Observed outputs and bench state
  logic        pready, pslverr, err, regulatorEnableOut, processorClock, procResetN, busResetN;
  logic        procLogicPowerOn, procMemPowerOn, topLogicPowerOn, topMemPowerOn, oscEnable;
  logic        ahbDownReq, ahbDownAck, axiDownReq, axiDownAck, selfRefreshReq, selfRefreshAck;
  logic        refSelExternal;
  logic [5:0]  domainPowerOn;
  logic [2:0]  pllEnable, clkFromPll, tg;
  int          badCount = 0, checkCount = 0, wn = 0, cycles = 0;
  logic [7:0]  offs [7] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h20, 8'h28, 8'h34};
  logic [31:0] rstv [7] = '{32'h0, 32'h3F, 32'h600A0000, 32'hFFFFFFFF, 32'h100, 32'h14, 32'h0};

  // Lock count cut to 20 cycles for short wakes
  scpmc_top #(.PLL_LOCK_CYCLES(16'h0014)) i_dut (
    .sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .opModeStrap, .wakeupEvent, .regulatorEnableOut, .standbyWaitInterrupt,
    .processorClock, .procResetN, .procLogicPowerOn, .procMemPowerOn, .topLogicPowerOn,
    .topMemPowerOn, .domainPowerOn, .ahbDownReq, .ahbDownAck, .axiDownReq, .axiDownAck,
    .selfRefreshReq, .selfRefreshAck, .busResetN, .refSelExternal, .oscEnable,
    .pllEnable, .clkFromPll, .hclkGated, .pclkGated, .sclkGated);
  scpmc_partner i_far (.sys_clk, .rst_n, .ackDelay, .ahbDownReq, .axiDownReq,
    .selfRefreshReq, .ahbDownAck, .axiDownAck, .selfRefreshAck);

  // Clock and hang guard
  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      reportAndStop;
    end
  end

  // Verdict
  task automatic reportAndStop;
    $display("checks %0d errors %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // APB master: request held until pready high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic doReset(input logic s);
    opModeStrap <= s;
    rst_n <= 1'h0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'h1;
    repeat (5) @(negedge sys_clk);
    `CHK({refSelExternal, domainPowerOn, regulatorEnableOut}, {s, 7'h7F})
  endtask

  task automatic pulseWfi;
    @(posedge sys_clk);
    standbyWaitInterrupt <= 1'h1;
    @(posedge sys_clk);
    standbyWaitInterrupt <= 1'h0;
  endtask

  task automatic wake(input logic v);
    @(posedge sys_clk);
    wakeupEvent <= v;
  endtask

  // Toggles of hclk[1:0] and core clock over 40 cycles
  task automatic watch;
    logic [2:0] p;
    repeat (2) @(negedge sys_clk);
    p = {hclkGated[1:0], processorClock};
    tg = 3'h0;
    repeat (40) begin
      @(negedge sys_clk);
      tg = tg | (p ^ {hclkGated[1:0], processorClock});
      p = {hclkGated[1:0], processorClock};
    end
  endtask

  task automatic tRegs;
    for (int i = 0; i < 7; i++) begin
      apb(1'h0, offs[i], 32'h0);
      `CHK({rd, err}, {rstv[i], i == 6})
    end
  endtask

  task automatic tClocks;
    apb(1'h1, 8'h10, 32'h0);
    for (int i = 0; i < 16; i += 15) begin
      apb(1'h1, 8'h0C, 32'(i));
      `WAITV(processorClock)
      `WAITV(!processorClock)
      `WAITV(processorClock)
      `WAITV(!processorClock)
      `WAITV(processorClock)
      `CHK(wn, i + 1)
    end
    apb(1'h1, 8'h14, 32'hFFFFFFFE);
    watch;
    `CHK(tg[2:1], 2'h2)
    apb(1'h1, 8'h14, 32'hFFFFFFFF);
    apb(1'h1, 8'h2C, 32'hF);
    `WAITV(clkFromPll == 3'h7)
    `CHK({pllEnable, clkFromPll}, 6'h3F)
  endtask

  task automatic tDomainsIdle;
    apb(1'h1, 8'h04, 32'h15);
    pulseWfi;
    repeat (3) @(negedge sys_clk);
    `CHK({domainPowerOn, ahbDownReq}, 7'h2A)
    apb(1'h1, 8'h04, 32'h3F);
    apb(1'h1, 8'h00, 32'h20);
    pulseWfi;
    `WAITV(!processorClock)
    watch;
    `CHK({tg[2], tg[0]}, 2'h2)
    apb(1'h0, 8'h30, 32'h0);
    `CHK(rd[3:0], 4'h1)
    wake(1'h1);
    `WAITV(processorClock)
    `CHK(processorClock, 1'h1)
    wake(1'h0);
  endtask

  task automatic tStop(input logic deep);
    apb(1'h1, 8'h08, deep ? 32'h40080000 : 32'h600A0000);
    apb(1'h1, 8'h20, 32'h20);
    apb(1'h1, 8'h00, 32'h40);
    ackDelay <= deep ? 4'h6 : 4'h0;
    pulseWfi;
    `WAITV(!oscEnable)
    @(negedge sys_clk);
    `CHK({domainPowerOn, procLogicPowerOn, procMemPowerOn}, {6'h00, !deep, !deep})
    `CHK({topLogicPowerOn, procResetN, pllEnable}, {1'h1, !deep, 3'h0})
    wake(1'h1);
    `WAITV(oscEnable)
    `WAITV(pllEnable == 3'h7)
    `CHK(wn >= 32, 1'h1)
    `WAITV(!ahbDownReq)
    @(negedge sys_clk);
    `CHK({procResetN, clkFromPll, domainPowerOn}, 10'h3FF)
    wake(1'h0);
    apb(1'h0, 8'h0C, 32'h0);
    `CHK(rd, 32'hF)
  endtask

  task automatic tSleep;
    apb(1'h1, 8'h24, 32'h10);
    apb(1'h1, 8'h00, 32'h60);
    pulseWfi;
    `WAITV(!regulatorEnableOut)
    @(negedge sys_clk);
    `CHK({busResetN, procResetN, oscEnable, domainPowerOn}, 9'h000)
    wake(1'h1);
    `WAITV(regulatorEnableOut)
    `WAITV(oscEnable)
    `CHK(wn >= 16, 1'h1)
    `WAITV(busResetN)
    `CHK(procResetN, 1'h0)
    `WAITV(procResetN)
    `CHK({ahbDownReq, regulatorEnableOut}, 2'h1)
    wake(1'h0);
  endtask

  // Main sequence, then a mid-run reset
  initial begin
    doReset(1'h1);
    tRegs;
    tClocks;
    tDomainsIdle;
    tStop(1'h0);
    tStop(1'h1);
    tSleep;
    doReset(1'h0);
    reportAndStop;
  end
endmodule
